// >>> hw/nfs_pkg.sv
// Package: shared constants and types for the two-district flash sequencer controller
package nfs_pkg;
  // Command bytes
  localparam logic [7:0] CMD_READ1     = 8'h00;
  localparam logic [7:0] CMD_READ_GO   = 8'h30;
  localparam logic [7:0] CMD_CB_READ   = 8'h35;
  localparam logic [7:0] CMD_PROG1     = 8'h80;
  localparam logic [7:0] CMD_PROG2     = 8'h81;
  localparam logic [7:0] CMD_COLCHG    = 8'h85;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_PROG_MID  = 8'h11;
  localparam logic [7:0] CMD_ERASE1    = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_STATUS2   = 8'h71;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  // Status byte fields
  localparam int ST_FAIL_BIT   = 0;
  localparam int ST_D0_BIT     = 1;
  localparam int ST_D1_BIT     = 2;
  localparam int ST_READY_BIT  = 6;
  localparam int ST_WP_BIT     = 7;
  // Geometry
  localparam int PAGE_IN_BLK_W = 6;
  localparam int BLK_W         = 11;
  localparam int ROW_W         = 17;
  localparam int COL_W         = 12;
  localparam int SECTOR_MAIN   = 512;
  localparam int SPARE_BASE    = 2048;
  localparam int SPARE_SECT    = 16;
  localparam int MAX_PROG_PER_PAGE = 4;
  // Strobe timing: each strobe phase held at least this long
  localparam int STROBE_NS     = 25;
  localparam int CLK_NS        = 5;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  // Operations the user may order
  typedef enum logic [3:0] {
    OP_READ    = 4'h0,
    OP_MREAD   = 4'h1,
    OP_PROG    = 4'h2,
    OP_MPROG   = 4'h3,
    OP_ERASE   = 4'h4,
    OP_MERASE  = 4'h5,
    OP_CBREAD  = 4'h6,
    OP_CBPROG  = 4'h7,
    OP_STATUS  = 4'h8,
    OP_STATUS2 = 4'h9,
    OP_RESET   = 4'hA
  } nfs_op_e;
  // One order from the user
  typedef struct packed {
    nfs_op_e            op;
    logic [ROW_W-1:0]   row_a;
    logic [ROW_W-1:0]   row_b;
    logic [COL_W-1:0]   col;
    logic [11:0]        nbytes;
  } nfs_req_s;
  // Bus cycle kinds
  typedef enum logic [4:0] {
    CY_IDLE = 5'b00001,
    CY_CMD  = 5'b00010,
    CY_ADDR = 5'b00100,
    CY_WR   = 5'b01000,
    CY_RD   = 5'b10000
  } nfs_cy_e;
endpackage

// >>> hw/nfs_fifo.sv
// Module: parameterised valid/ready FIFO for the program data path
`timescale 1ns/1ps
`default_nettype none
module nfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } nfs_fst_s;
  nfs_fst_s             st_q;
  nfs_fst_s             st_d;
  logic [WIDTH-1:0]     mem [DEPTH];
  logic                 push;
  logic                 pop;

  // ---------------------------------------------------------------
  // Flags and pointers
  // ---------------------------------------------------------------
  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = mem[st_q.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Next pointer values
  always_comb begin
    st_d = st_q;
    if (push) st_d.wp = st_q.wp + 1'b1;
    if (pop)  st_d.rp = st_q.rp + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) mem[st_q.wp] <= in_data;
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) st_q <= '0;
    else     st_q <= st_d;
  end
endmodule
`default_nettype wire

// >>> hw/nfs_host.sv
// Module: host controller driving a two-district NAND flash over its byte-wide pins
// ---------------------------------------------------------------
// Summary of operation
// - Multi operations pick at most one block per district, any order.
// - Multi read and program use equal page index in both districts.
// - Multi read sends 60h plus address per district, then 30h.
// - Write protect stays high throughout a multi page read.
// - Program whole sectors, at most 4 programs per page per erase; neither is checked here, nbytes bytes go out as ordered.
// - 85h plus two column cycles moves the data column, repeatable.
// - Multi program is 80h,addr,data,11h,81h,addr,data,10h.
// - Inside multi sequences only 70h or FFh may be inserted.
// - Multi erase sends two 60h-addressed blocks then one D0h.
// - Multi erase ends with D0h, or FFh to abandon.
// - Copy-back program: 85h, destination, optional 85h changes, then 10h.
// - Copy-back source and destination share one district.
// ---------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module nfs_host #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic            CLK,
  input  wire logic            SYS_RST,
  // User side
  input  wire logic            REQ_VALID,
  input  wire nfs_pkg::nfs_req_s REQ,
  output logic                 REQ_READY,
  output logic                 REQ_ERR,
  input  wire logic [7:0]      WDATA,
  input  wire logic            WDATA_VALID,
  output logic                 WDATA_READY,
  output logic [7:0]           RDATA,
  output logic                 RDATA_VALID,
  output logic                 DONE,
  output logic [7:0]           STATUS,
  // Flash pins
  output logic                 NF_CE_N,
  output logic                 NF_CLE,
  output logic                 NF_ALE,
  output logic                 NF_WE_N,
  output logic                 NF_RE_N,
  output logic                 NF_WP_N,
  output logic [7:0]           NF_IO_O,
  output logic                 NF_IO_OE,
  input  wire logic [7:0]      NF_IO_I,
  input  wire logic            NF_READY_BUSY_N
);
  localparam logic [2:0] STB = 3'(nfs_pkg::STROBE_CYC);

  typedef enum logic [7:0] {
    S_IDLE  = 8'b0000_0001,
    S_STEP  = 8'b0000_0010,
    S_CYC   = 8'b0000_0100,
    S_BUSYW = 8'b0000_1000,
    S_BUSY  = 8'b0001_0000,
    S_DATA  = 8'b0010_0000,
    S_STAT  = 8'b0100_0000,
    S_FIN   = 8'b1000_0000
  } nfs_st_e;

  // Whole controller state in one struct
  typedef struct packed {
    nfs_st_e            st;
    nfs_pkg::nfs_req_s  req;
    logic [4:0]         step;
    logic [2:0]         addr_i;
    logic [2:0]         tick;
    logic               half;
    nfs_pkg::nfs_cy_e   cy;
    logic [7:0]         byte_o;
    logic [11:0]        cnt;
    logic [2:0]         rb_sync;
    logic               rb_ok;
    logic               ce_n;
    logic               cle;
    logic               ale;
    logic               we_n;
    logic               re_n;
    logic               wp_n;
    logic               oe;
    logic               req_ready;
    logic               req_err;
    logic [7:0]         rdata;
    logic               rvalid;
    logic               done;
    logic [7:0]         status;
  } nfs_hst_s;

  nfs_hst_s   s_q;
  nfs_hst_s   s_d;
  logic [7:0] f_data;
  logic       f_valid;
  logic       f_pop;
  logic       f_in_ready;

  // ---------------------------------------------------------------
  // Program data buffer; WDATA_READY back-pressures the user
  // ---------------------------------------------------------------
  nfs_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLK),
    .rst       (SYS_RST),
    .in_data   (WDATA),
    .in_valid  (WDATA_VALID),
    .in_ready  (f_in_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );
  assign WDATA_READY = f_in_ready;

  // Legality of an order, checked before any pin moves
  function automatic logic req_bad(input nfs_pkg::nfs_req_s r);
    logic da;
    logic db;
    da = r.row_a[nfs_pkg::PAGE_IN_BLK_W];
    db = r.row_b[nfs_pkg::PAGE_IN_BLK_W];
    req_bad = 1'b0;
    if (r.op == nfs_pkg::OP_MREAD || r.op == nfs_pkg::OP_MPROG ||
        r.op == nfs_pkg::OP_MERASE)
      req_bad = (da == db);
    if (r.op == nfs_pkg::OP_MREAD || r.op == nfs_pkg::OP_MPROG)
      req_bad = req_bad || (r.row_a[5:0] != r.row_b[5:0]);
    if (r.op == nfs_pkg::OP_CBPROG)
      req_bad = (da != db);
  endfunction

  // Script: step -> (kind, byte). Address steps expand to cycles.
  // Kinds: 0 cmd, 1 col addr(2), 2 full addr(5) row_a, 3 full addr row_b,
  // 4 row addr(3) row_a, 5 row addr row_b, 6 write data, 7 busy wait,
  // 8 read data, 9 status read, 15 end
  function automatic logic [11:0] script(input nfs_pkg::nfs_op_e op,
                                         input logic [4:0] n);
    script = {4'd15, 8'h00};
    case (op)
      nfs_pkg::OP_READ, nfs_pkg::OP_CBREAD: begin
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_READ1};
          5'd1: script = {4'd2, 8'h00};
          5'd2: script = {4'd0, (op == nfs_pkg::OP_CBREAD) ?
                          nfs_pkg::CMD_CB_READ : nfs_pkg::CMD_READ_GO};
          5'd3: script = {4'd7, 8'h00};
          5'd4: script = (op == nfs_pkg::OP_READ) ? {4'd8, 8'h00} :
                         {4'd0, nfs_pkg::CMD_STATUS};
          5'd5: script = (op == nfs_pkg::OP_READ) ? {4'd15, 8'h00} : {4'd9, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_MREAD: begin
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_ERASE1};
          5'd1: script = {4'd4, 8'h00};
          5'd2: script = {4'd0, nfs_pkg::CMD_ERASE1};
          5'd3: script = {4'd5, 8'h00};
          5'd4: script = {4'd0, nfs_pkg::CMD_READ_GO};
          5'd5: script = {4'd7, 8'h00};
          5'd6: script = {4'd8, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_CBPROG: begin
        // Destination, then a column change so modified data lands at col
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_COLCHG};
          5'd1: script = {4'd3, 8'h00};
          5'd2: script = {4'd0, nfs_pkg::CMD_COLCHG};
          5'd3: script = {4'd1, 8'h00};                 // two column cycles
          5'd4: script = {4'd6, 8'h00};
          5'd5: script = {4'd0, nfs_pkg::CMD_PROG_GO};
          5'd6: script = {4'd7, 8'h00};
          5'd7: script = {4'd0, nfs_pkg::CMD_STATUS};
          5'd8: script = {4'd9, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_PROG: begin
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_PROG1};
          5'd1: script = {4'd3, 8'h00};
          5'd2: script = {4'd6, 8'h00};
          5'd3: script = {4'd0, nfs_pkg::CMD_PROG_GO};
          5'd4: script = {4'd7, 8'h00};
          5'd5: script = {4'd0, nfs_pkg::CMD_STATUS};
          5'd6: script = {4'd9, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_MPROG: begin
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_PROG1};
          5'd1: script = {4'd2, 8'h00};
          5'd2: script = {4'd6, 8'h00};
          5'd3: script = {4'd0, nfs_pkg::CMD_PROG_MID};
          5'd4: script = {4'd7, 8'h00};
          5'd5: script = {4'd0, nfs_pkg::CMD_PROG2};
          5'd6: script = {4'd3, 8'h00};
          5'd7: script = {4'd6, 8'h00};
          5'd8: script = {4'd0, nfs_pkg::CMD_PROG_GO};
          5'd9: script = {4'd7, 8'h00};
          5'd10: script = {4'd0, nfs_pkg::CMD_STATUS2};
          5'd11: script = {4'd9, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_ERASE, nfs_pkg::OP_MERASE: begin
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_ERASE1};
          5'd1: script = {4'd4, 8'h00};
          5'd2: script = (op == nfs_pkg::OP_MERASE) ?
                         {4'd0, nfs_pkg::CMD_ERASE1} : {4'd0, nfs_pkg::CMD_ERASE_GO};
          5'd3: script = (op == nfs_pkg::OP_MERASE) ? {4'd5, 8'h00} : {4'd7, 8'h00};
          5'd4: script = (op == nfs_pkg::OP_MERASE) ?
                         {4'd0, nfs_pkg::CMD_ERASE_GO} :
                         {4'd0, nfs_pkg::CMD_STATUS};
          5'd5: script = (op == nfs_pkg::OP_MERASE) ? {4'd7, 8'h00} : {4'd9, 8'h00};
          5'd6: script = (op == nfs_pkg::OP_MERASE) ?
                         {4'd0, nfs_pkg::CMD_STATUS2} : {4'd15, 8'h00};
          5'd7: script = (op == nfs_pkg::OP_MERASE) ? {4'd9, 8'h00} : {4'd15, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_STATUS, nfs_pkg::OP_STATUS2: begin
        case (n)
          5'd0: script = {4'd0, (op == nfs_pkg::OP_STATUS) ?
                          nfs_pkg::CMD_STATUS : nfs_pkg::CMD_STATUS2};
          5'd1: script = {4'd9, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      nfs_pkg::OP_RESET: begin
        case (n)
          5'd0: script = {4'd0, nfs_pkg::CMD_RESET};
          5'd1: script = {4'd7, 8'h00};
          default: script = {4'd15, 8'h00};
        endcase
      end
      default: script = {4'd15, 8'h00};
    endcase
  endfunction

  // Address byte k of the current script step
  function automatic logic [7:0] addr_byte(input logic [3:0] kind,
                                           input nfs_pkg::nfs_req_s r,
                                           input logic [2:0] k);
    logic [16:0] row;
    logic [2:0]  idx;
    row = (kind == 4'd3 || kind == 4'd5) ? r.row_b : r.row_a;
    idx = (kind == 4'd4 || kind == 4'd5) ? k + 3'd2 : k;
    case (idx)
      3'd0:    addr_byte = r.col[7:0];
      3'd1:    addr_byte = {4'h0, r.col[11:8]};
      3'd2:    addr_byte = row[7:0];
      3'd3:    addr_byte = row[15:8];
      3'd4:    addr_byte = {7'h00, row[16]};
      default: addr_byte = 8'h00;
    endcase
  endfunction

  // Number of address cycles per kind
  function automatic logic [2:0] addr_len(input logic [3:0] kind);
    case (kind)
      4'd1:       addr_len = 3'd2;
      4'd2, 4'd3: addr_len = 3'd5;
      4'd4, 4'd5: addr_len = 3'd3;
      default:    addr_len = 3'd0;
    endcase
  endfunction

  logic [11:0] cur;
  logic [3:0]  kind;
  logic        rb_ready;
  assign cur      = script(s_q.req.op, s_q.step);
  assign kind     = cur[11:8];
  assign rb_ready = s_q.rb_ok;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    s_d        = s_q;
    s_d.done   = 1'b0;
    s_d.rvalid = 1'b0;
    s_d.req_err = 1'b0;
    // Three-stage pin sync; change accepted when stages 2 and 3 agree
    s_d.rb_sync = {s_q.rb_sync[1:0], NF_READY_BUSY_N};
    if (s_q.rb_sync[2] == s_q.rb_sync[1]) s_d.rb_ok = s_q.rb_sync[2];
    f_pop = 1'b0;
    case (s_q.st)
      S_IDLE: begin
        if (REQ_VALID && s_q.req_ready) begin
          s_d.req       = REQ;
          s_d.step      = 5'd0;
          s_d.req_ready = 1'b0;
          if (req_bad(REQ)) begin
            s_d.req_err   = 1'b1;
            s_d.req_ready = 1'b1;
          end else begin
            s_d.st   = S_STEP;
            s_d.ce_n = 1'b0;
            s_d.wp_n = (REQ.op != nfs_pkg::OP_RESET);
          end
        end
      end
      S_STEP: begin
        s_d.addr_i = 3'd0;
        s_d.cnt    = 12'd0;
        case (kind)
          4'd0: begin
            s_d.cy = nfs_pkg::CY_CMD;
            s_d.byte_o = cur[7:0];
            s_d.st = S_CYC;
          end
          4'd1, 4'd2, 4'd3, 4'd4, 4'd5: begin
            s_d.cy = nfs_pkg::CY_ADDR;
            s_d.byte_o = addr_byte(kind, s_q.req, 3'd0);
            s_d.st = S_CYC;
          end
          4'd6, 4'd8: s_d.st = S_DATA;
          4'd7: begin
            s_d.st   = S_BUSYW;
            s_d.tick = STB;
          end
          4'd9: begin
            s_d.cy = nfs_pkg::CY_RD;
            s_d.st = S_CYC;
          end
          default: s_d.st = S_FIN;
        endcase
        s_d.half = 1'b0;
      end
      S_DATA: begin
        if (s_q.cnt == s_q.req.nbytes) begin            // nbytes bytes per data step, read or write
          s_d.step = s_q.step + 5'd1;
          s_d.st   = S_STEP;
        end else if (kind == 4'd8) begin
          s_d.cy = nfs_pkg::CY_RD;
          s_d.st = S_CYC;
        end else if (f_valid) begin
          f_pop      = 1'b1;
          s_d.byte_o = f_data;
          s_d.cy     = nfs_pkg::CY_WR;
          s_d.st     = S_CYC;
        end
      end
      S_CYC: begin
        // A setup phase, then one strobe phase low, one high, each STB+1 cycles long
        s_d.cle = (s_q.cy == nfs_pkg::CY_CMD);
        s_d.ale = (s_q.cy == nfs_pkg::CY_ADDR);
        s_d.oe  = (s_q.cy != nfs_pkg::CY_RD);
        if (s_q.tick != STB) begin
          s_d.tick = s_q.tick + 3'd1;
        end else begin
          s_d.tick = 3'd0;
          if (!s_q.half) begin
            s_d.half = 1'b1;
            if (s_q.cy == nfs_pkg::CY_RD) s_d.re_n = 1'b0;
            else                          s_d.we_n = 1'b0;
          end else if (!s_q.we_n || !s_q.re_n) begin
            // Rise only: byte and latch lines hold a full phase past it
            s_d.we_n = 1'b1;                            // start on rise
            s_d.re_n = 1'b1;
            if (s_q.cy == nfs_pkg::CY_RD) begin
              s_d.rdata  = NF_IO_I;
              s_d.rvalid = (kind == 4'd8);
              if (kind == 4'd9) s_d.status = NF_IO_I;
            end
          end else begin
            s_d.half = 1'b0;
            if (s_q.cy == nfs_pkg::CY_ADDR &&
                s_q.addr_i + 3'd1 != addr_len(kind)) begin
              s_d.addr_i = s_q.addr_i + 3'd1;
              s_d.byte_o = addr_byte(kind, s_q.req, s_q.addr_i + 3'd1);
            end else if (kind == 4'd6 || kind == 4'd8) begin
              s_d.cnt = s_q.cnt + 12'd1;
              s_d.st  = S_DATA;
            end else begin
              s_d.cle  = 1'b0;
              s_d.ale  = 1'b0;
              s_d.step = s_q.step + 5'd1;
              s_d.st   = S_STEP;
            end
          end
        end
      end
      S_BUSYW: begin
        // Give the device time to pull busy low before watching it
        if (s_q.tick == 3'd0) s_d.st = S_BUSY;
        else s_d.tick = s_q.tick - 3'd1;
      end
      S_BUSY: begin
        if (rb_ready) begin
          s_d.step = s_q.step + 5'd1;
          s_d.st   = S_STEP;
        end
      end
      S_FIN: begin
        s_d.ce_n      = 1'b1;
        s_d.oe        = 1'b0;
        s_d.done      = 1'b1;
        s_d.req_ready = 1'b1;
        s_d.st        = S_IDLE;
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      s_q           <= '0;
      s_q.st        <= S_IDLE;
      s_q.cy        <= nfs_pkg::CY_IDLE;
      s_q.rb_sync   <= 3'b111;
      s_q.rb_ok     <= 1'b1;
      s_q.ce_n      <= 1'b1;
      s_q.we_n      <= 1'b1;
      s_q.re_n      <= 1'b1;
      s_q.wp_n      <= 1'b0;
      s_q.req_ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs straight from the state register
  // ---------------------------------------------------------------
  assign REQ_READY   = s_q.req_ready;
  assign REQ_ERR     = s_q.req_err;
  assign RDATA       = s_q.rdata;
  assign RDATA_VALID = s_q.rvalid;
  assign DONE        = s_q.done;
  assign STATUS      = s_q.status;
  assign NF_CE_N     = s_q.ce_n;
  assign NF_CLE      = s_q.cle;
  assign NF_ALE      = s_q.ale;
  assign NF_WE_N     = s_q.we_n;
  assign NF_RE_N     = s_q.re_n;
  assign NF_WP_N     = s_q.wp_n;
  assign NF_IO_O     = s_q.byte_o;
  assign NF_IO_OE    = s_q.oe;
endmodule
`default_nettype wire

// >>> verification/nfs_host_asserts.sv
// Checker: pin and handshake properties of the flash host controller
`timescale 1ns/1ps
`default_nettype none
module nfs_host_asserts (
  input wire logic       CLK,
  input wire logic       SYS_RST,
  input wire logic       REQ_VALID,
  input wire logic       REQ_READY,
  input wire logic       REQ_ERR,
  input wire logic       DONE,
  input wire logic       NF_CE_N,
  input wire logic       NF_CLE,
  input wire logic       NF_ALE,
  input wire logic       NF_WE_N,
  input wire logic       NF_RE_N,
  input wire logic       NF_WP_N,
  input wire logic [7:0] NF_IO_O,
  input wire logic       NF_IO_OE
);
  // One domain, so one clock for all and one reset for all but a_reset_idle
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  a_reset_idle: assert property (disable iff (1'b0)
    SYS_RST |=> NF_CE_N && NF_WE_N && !NF_WP_N && REQ_READY) else $error("not idle after reset");
  a_err_cause: assert property (REQ_ERR |-> $past(REQ_VALID && REQ_READY))
    else $error("refusal without an order");
  a_err_quiet: assert property (REQ_ERR |-> NF_CE_N && $past(NF_CE_N))
    else $error("pins moved on a refused order");
  a_err_pulse: assert property (REQ_ERR |=> !REQ_ERR) else $error("refusal too long");
  a_done_pulse: assert property (DONE |=> !DONE) else $error("done too long");
  a_take_busy: assert property (REQ_VALID && REQ_READY |=> REQ_ERR == REQ_READY)
    else $error("second order accepted while busy");
  a_lane_excl: assert property (!(NF_CLE && NF_ALE)) else $error("command and address both");
  a_wp_read: assert property ($fell(NF_RE_N) |-> NF_WP_N) else $error("protect low on read");
  a_we_width: assert property ($fell(NF_WE_N) |-> !NF_WE_N [*4])
    else $error("write strobe too short");
  a_cmd_latch: assert property ($rose(NF_WE_N) && NF_CLE |-> NF_IO_OE && $stable(NF_IO_O))
    else $error("command byte not held to strobe rise");
  a_oe_read: assert property (!NF_RE_N |-> !NF_IO_OE) else $error("bus fight on read");
  // Main scenarios reached
  c_done: cover property (DONE);
  c_refused: cover property (REQ_ERR);
  c_erase_go: cover property ($rose(NF_WE_N) && NF_CLE && NF_IO_O == 8'hD0);
endmodule
bind nfs_host nfs_host_asserts u_chk (.*);
`default_nettype wire

// >>> verification/nfs_dev_model.sv
// Model: two-district flash device answering the host controller pins
`timescale 1ns/1ps
`default_nettype none
module nfs_dev_model (
  input  wire logic       clk,
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       re_n,
  input  wire logic       wp_n,
  input  wire logic [7:0] io_o,
  input  wire logic       fail0,
  input  wire logic       fail1,
  output logic [7:0]      io_i,
  output logic            rb_n
);
  logic [39:0] cseq;
  logic [7:0]  dat[$];
  logic [7:0]  st, rdp, last;
  logic        we_q, re_q, smode, s71, pe;
  int          naddr, busy;
  // Fail bits show only after program or erase; 71h splits them by district
  assign st = {wp_n, rb_n, rb_n, 2'b00, pe & fail1 & s71, pe & fail0 & s71, pe & (fail0 | fail1)};
  initial begin
    {cseq, rdp, last, we_q, re_q, smode, s71, pe, naddr, busy} = '0;
    rb_n = 1'b1;
    io_i = 8'h5A;
  end
  // Bytes latch on the write strobe rise; busy is counted in clocks
  always @(posedge clk) begin
    if (we_n && !we_q && !ce_n) begin
      if (cle) begin
        cseq = {cseq[31:0], io_o};
        smode = io_o inside {8'h70, 8'h71};
        s71 = io_o == 8'h71;
        if (io_o inside {8'h10, 8'hD0}) pe = 1'b1;
        if (io_o inside {8'h30, 8'h35}) begin
          pe = 1'b0;
          rdp = 8'hA0;
        end
        if (io_o inside {8'h10, 8'h11, 8'h30, 8'h35, 8'hD0, 8'hFF}) busy = 24;
      end else if (ale) naddr++;
      else dat.push_back(io_o);
    end
    if (!re_n && re_q) last = smode ? st : rdp;
    if (re_n && !re_q && !smode) rdp++;
    if (busy > 0) busy--;
    we_q = we_n;
    re_q = re_n;
    rb_n <= busy == 0;
    // A released bus shows the inverse so a late sample cannot match
    io_i <= re_n ? ~last : last;
  end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// Testbench: order sequences for the flash host controller against a device model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic              CLK, SYS_RST, REQ_VALID, WDATA_VALID, fail0, fail1;
  nfs_pkg::nfs_req_s REQ;
  logic [7:0]        WDATA, NF_IO_I, NF_IO_O, RDATA, STATUS;
  logic              REQ_READY, REQ_ERR, WDATA_READY, RDATA_VALID, DONE, NF_CE_N, NF_CLE;
  logic              NF_ALE, NF_WE_N, NF_RE_N, NF_WP_N, NF_IO_OE, NF_READY_BUSY_N;
  logic [7:0]        rq[$];
  int                n_errors, cmp_count;
  nfs_host #(.FIFO_DEPTH(16)) uut (.*);
  nfs_dev_model dev (.clk(CLK), .ce_n(NF_CE_N), .cle(NF_CLE), .ale(NF_ALE), .we_n(NF_WE_N),
    .re_n(NF_RE_N), .wp_n(NF_WP_N), .io_o(NF_IO_O), .fail0(fail0), .fail1(fail1),
    .io_i(NF_IO_I), .rb_n(NF_READY_BUSY_N));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  // Program data streams without pause, so the buffer fills and refuses first
  always @(posedge CLK) if (WDATA_VALID && WDATA_READY && !SYS_RST) WDATA <= WDATA + 8'h01;
  always @(negedge CLK) if (RDATA_VALID === 1'b1) rq.push_back(RDATA);
  task automatic chk(string nm, logic [39:0] got, logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // One order: wait idle, present it for one edge, wait for done or refusal
  task automatic go(logic [3:0] op, logic [16:0] ra, logic [16:0] rb, logic [11:0] nb,
                    logic eerr, logic [39:0] ecmd, int enad, logic [7:0] est);
    int k;
    k = 0;
    do @(negedge CLK); while (REQ_READY !== 1'b1);
    dev.cseq = 40'hEE_EEEE_EEEE;
    dev.naddr = 0;
    dev.dat.delete();
    rq.delete();
    @(posedge CLK);
    REQ_VALID <= 1'b1;
    REQ <= '{nfs_pkg::nfs_op_e'(op), ra, rb, 12'h000, nb};
    @(posedge CLK);
    REQ_VALID <= 1'b0;
    do @(negedge CLK); while (DONE !== 1'b1 && REQ_ERR !== 1'b1 && ++k < 20000);
    chk("order finished", k < 20000, 1'b1);
    chk("refusal", REQ_ERR, eerr);
    chk("command bytes", dev.cseq, ecmd);
    chk("address cycles", dev.naddr, enad);
    if (est != 0) chk("status byte", STATUS, est);
  endtask
  initial begin
    #400000;
    n_errors++;
    final_report();
  end
  initial begin
    {SYS_RST, REQ_VALID, REQ, WDATA, WDATA_VALID, fail0, fail1} = '0;
    SYS_RST = 1'b1;
    WDATA_VALID = 1'b1;
    repeat (3) @(posedge CLK);
    SYS_RST <= 1'b0;
    @(negedge CLK);
    chk("idle pins", {NF_CE_N, NF_WE_N, NF_RE_N, NF_WP_N, REQ_READY}, 5'b11101);
    repeat (3) @(posedge CLK);
    go(4'h5, 17'h0_0040, 17'h0_00C0, 0, 1, 40'hEE_EEEE_EEEE, 0, 0);
    go(4'h1, 17'h0_0041, 17'h0_0080, 2, 1, 40'hEE_EEEE_EEEE, 0, 0);
    go(4'h7, 17'h0_0040, 17'h0_0080, 0, 1, 40'hEE_EEEE_EEEE, 0, 0);
    go(4'h4, 17'h0_0040, 17'h0_0040, 0, 0, 40'hEE_EE60_D070, 3, 8'hE0);
    fail1 = 1'b1;
    go(4'h5, 17'h0_0040, 17'h0_0080, 0, 0, 40'hEE_6060_D071, 6, 8'hE5);
    go(4'h3, 17'h0_0041, 17'h0_0081, 2, 0, 40'h80_1181_1071, 10, 8'hE5);
    fail1 = 1'b0;
    fail0 = 1'b1;
    go(4'h2, 17'h0_0040, 17'h0_0080, 4, 0, 40'hEE_EE80_1070, 5, 8'hE1);
    chk("data bytes", dev.dat.size(), 4);
    chk("first data", dev.dat[0], 8'h04);
    fail0 = 1'b0;
    go(4'h0, 17'h0_0040, 17'h0_0040, 3, 0, 40'hEE_EEEE_0030, 5, 0);
    chk("read bytes", rq.size(), 3);
    chk("last read", rq[2], 8'hA2);
    go(4'h1, 17'h0_0041, 17'h0_0081, 2, 0, 40'hEE_EE60_6030, 6, 0);
    chk("multi read", rq[1], 8'hA1);
    go(4'h6, 17'h0_0040, 17'h0_0040, 0, 0, 40'hEE_EE00_3570, 5, 8'hE0);
    go(4'h7, 17'h0_0040, 17'h0_00C0, 0, 0, 40'hEE_8585_1070, 7, 8'hE0);
    go(4'h8, 17'h0_0040, 17'h0_0040, 0, 0, 40'hEE_EEEE_EE70, 0, 8'hE0);
    fail1 = 1'b1;
    go(4'h9, 17'h0_0040, 17'h0_0040, 0, 0, 40'hEE_EEEE_EE71, 0, 8'hE5);
    fail1 = 1'b0;
    go(4'hA, 17'h0_0040, 17'h0_0040, 0, 0, 40'hEE_EEEE_EEFF, 0, 0);
    final_report();
  end
endmodule
`default_nettype wire
